// file: inc/ceh_params.svh
`ifndef CEH_PARAMS_SVH
`define CEH_PARAMS_SVH
// Contract
// [RL1] Recognise reset, address, interrupts, traps, undefined, FPU, privileged
// [RL2] One fixed reset vector for every cause
// [RL3] Three readable reset status registers hold cause
// [RL4] 64-bit operand off 32-bit boundary: address exception
// [RL5] Prohibited areas left to memory protection unit
// [RL6] Address exception saves faulting instruction PC
// [RL7] Separate vector tables for maskable and NMI
// [RL8] Fast interrupt path for priority level 15
// [RL9] 16 dedicated traps, 256 trap numbers total
// [RL10] Undefined opcode raises undefined instruction exception
// [RL11] Integer division never raises an exception
// [RL12] Accepted exception clears interrupt enable flag; the reset entry leaves it set
// [RL13] Enter supervisor mode, restore mode on return

// ==========================================================
// Vectors, offsets, limits, masks and reset values
`define CEH_RESET_VEC    32'hFFFF_FFFC
`define CEH_OFS_PRIV     32'h0000_0050
`define CEH_OFS_ACCESS   32'h0000_0054
`define CEH_OFS_UNDEF    32'h0000_005C
`define CEH_OFS_FPU      32'h0000_0064
`define CEH_OFS_NMI      32'h0000_0078
`define CEH_OFS_ADDR     32'h0000_0058
`define CEH_VEC_SHIFT    2
`define CEH_FAST_LEVEL   4'hF
`define CEH_TRAP_DEDIC   8'h10
`define CEH_ALIGN_MASK   3'h3
`define CEH_STAT_RST     8'h00
`define CEH_PSW_IE_RST   1'b1
`define CEH_PSW_PM_RST   1'b0
`endif

// file: inc/ceh_pkg.sv
package ceh_pkg;
  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    CEH_ST_BOOT = 2'b01,
    CEH_ST_RUN  = 2'b10
  } ceh_state_t;

  // ==========================================================
  // Kind of exception taken
  typedef enum logic [3:0] {
    CEH_K_NONE   = 4'h0,
    CEH_K_RESET  = 4'h1,
    CEH_K_NMI    = 4'h2,
    CEH_K_IRQ    = 4'h3,
    CEH_K_FAST   = 4'h4,
    CEH_K_UNDEF  = 4'h5,
    CEH_K_PRIV   = 4'h6,
    CEH_K_TRAP   = 4'h7,
    CEH_K_ADDR   = 4'h8,
    CEH_K_FPU    = 4'h9
  } ceh_kind_t;
endpackage

// file: rtl/ceh_exception_unit.sv
`timescale 1ns/100ps
`include "ceh_params.svh"

module ceh_exception_unit (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              en_i,
  // Reset cause snapshot from the reset generator
  input  wire logic [7:0]        rst_cause0_i,
  input  wire logic [7:0]        rst_cause1_i,
  input  wire logic [7:0]        rst_cause2_i,
  // Table bases owned by the core
  input  wire logic [31:0]       intb_i,
  input  wire logic [31:0]       extb_i,
  input  wire logic [31:0]       fintv_i,
  input  wire logic [3:0]        ipl_i,
  // Instruction in execute
  input  wire logic              instr_valid_i,
  input  wire logic [31:0]       instr_pc_i,
  input  wire logic [31:0]       resume_pc_i,
  input  wire logic              undef_op_i,
  input  wire logic              priv_op_i,
  input  wire logic              fpu_exc_i,
  input  wire logic              trap_i,
  input  wire logic              break_trap_instruction_i,
  input  wire logic [7:0]        trap_num_i,
  input  wire logic              opnd64_i,
  input  wire logic [31:0]       opnd_addr_i,
  input  wire logic              rte_i,
  input  wire logic              psw_wr_i,
  input  wire logic              psw_wr_ie_i,
  input  wire logic              psw_wr_pm_i,
  // Interrupt controller
  input  wire logic              nmi_i,
  input  wire logic              irq_i,
  input  wire logic [3:0]        irq_level_i,
  input  wire logic [7:0]        irq_vec_i,
  input  wire logic              irq_fast_i,
  // Results
  output logic                   take_o,
  output ceh_pkg::ceh_kind_t     kind_o,
  output logic [31:0]            vec_o,
  output logic [31:0]            save_pc_o,
  output logic                   irq_ack_o,
  output logic                   dedic_trap_o,
  output logic                   psw_ie_o,
  output logic                   psw_pm_o,
  output logic [7:0]             rst_stat0_o,
  output logic [7:0]             rst_stat1_o,
  output logic [7:0]             rst_stat2_o
);
  import ceh_pkg::*;

  // ==========================================================
  // State
  ceh_state_t  state;
  ceh_state_t  next_state;
  logic        take;
  logic        next_take;
  ceh_kind_t   kind;
  ceh_kind_t   next_kind;
  logic [31:0] vec;
  logic [31:0] next_vec;
  logic [31:0] save_pc;
  logic [31:0] next_save_pc;
  logic        irq_ack;
  logic        next_irq_ack;
  logic        dedic;
  logic        next_dedic;
  logic        psw_ie;
  logic        next_psw_ie;
  logic        psw_pm;
  logic        next_psw_pm;
  logic        bk_ie;
  logic        next_bk_ie;
  logic        bk_pm;
  logic        next_bk_pm;
  logic [7:0]  stat0;
  logic [7:0]  next_stat0;
  logic [7:0]  stat1;
  logic [7:0]  next_stat1;
  logic [7:0]  stat2;
  logic [7:0]  next_stat2;

  // ==========================================================
  // Cause decode
  logic        misalign;
  logic        irq_ok;
  logic        is_fast;
  logic        priv_hit;
  logic        any_trap;
  logic [31:0] irq_vec;
  logic [31:0] trap_vec;

  // Only 64-bit operands check alignment; narrower ones never fault
  assign misalign = instr_valid_i & opnd64_i &
                    ((opnd_addr_i[2:0] & `CEH_ALIGN_MASK) != 3'h0); // [RL4]
  // Prohibited regions are not decoded here; the MPU flags them [RL5]
  // No division term exists, so divide faults cannot trap [RL11]
  assign irq_ok   = irq_i & psw_ie & (irq_level_i > ipl_i);       // [RL12]
  assign is_fast  = irq_fast_i & (irq_level_i == `CEH_FAST_LEVEL); // [RL8]
  // Privileged opcodes only fault in user mode
  assign priv_hit = instr_valid_i & priv_op_i & psw_pm;
  // Break is trap number zero of the interrupt table
  assign any_trap = instr_valid_i & (trap_i | break_trap_instruction_i);
  // Interrupt table entries are four bytes each
  assign irq_vec  = intb_i + {22'h00_0000, irq_vec_i, 2'b00};      // [RL7]
  assign trap_vec = break_trap_instruction_i ? intb_i :
                    intb_i + {22'h00_0000, trap_num_i, 2'b00};     // [RL9]

  // ==========================================================
  // Next-state logic: priority is reset, NMI, interrupt, undefined
  // or privileged, trap, address, floating point
  always_comb begin
    next_state   = state;
    next_take    = 1'b0;
    next_kind    = CEH_K_NONE;
    next_vec     = vec;
    next_save_pc = save_pc;
    next_irq_ack = 1'b0;
    next_dedic   = 1'b0;
    next_psw_ie  = psw_ie;
    next_psw_pm  = psw_pm;
    next_bk_ie   = bk_ie;
    next_bk_pm   = bk_pm;
    next_stat0   = stat0;
    next_stat1   = stat1;
    next_stat2   = stat2;
    case (state)
      CEH_ST_BOOT: begin
        // Cause is caught after release, every reset shares one entry
        next_stat0  = rst_cause0_i;                       // [RL3]
        next_stat1  = rst_cause1_i;                       // [RL3]
        next_stat2  = rst_cause2_i;                       // [RL3]
        next_take   = 1'b1;
        next_kind   = CEH_K_RESET;
        next_vec    = `CEH_RESET_VEC;                     // [RL2]
        next_state  = CEH_ST_RUN;
      end
      CEH_ST_RUN: begin
        if (psw_wr_i) begin
          next_psw_ie = psw_wr_ie_i;
          next_psw_pm = psw_wr_pm_i;
        end
        if (rte_i) begin
          next_psw_ie = bk_ie;
          next_psw_pm = bk_pm;                            // [RL13]
        end
        next_take = 1'b1;
        if (nmi_i) begin
          next_kind    = CEH_K_NMI;
          next_vec     = extb_i + `CEH_OFS_NMI;           // [RL7]
          next_save_pc = resume_pc_i;
        end else if (irq_ok && is_fast) begin
          next_kind    = CEH_K_FAST;
          next_vec     = fintv_i;                         // [RL8]
          next_save_pc = resume_pc_i;
          next_irq_ack = 1'b1;
        end else if (irq_ok) begin
          next_kind    = CEH_K_IRQ;
          next_vec     = irq_vec;                         // [RL7]
          next_save_pc = resume_pc_i;
          next_irq_ack = 1'b1;
        end else if (instr_valid_i && undef_op_i) begin
          next_kind    = CEH_K_UNDEF;
          next_vec     = extb_i + `CEH_OFS_UNDEF;         // [RL10]
          next_save_pc = instr_pc_i;
        end else if (priv_hit) begin
          next_kind    = CEH_K_PRIV;
          next_vec     = extb_i + `CEH_OFS_PRIV;          // [RL1]
          next_save_pc = instr_pc_i;
        end else if (any_trap) begin
          next_kind    = CEH_K_TRAP;
          next_vec     = trap_vec;                        // [RL9]
          next_save_pc = resume_pc_i;
          next_dedic   = break_trap_instruction_i |
                         (trap_num_i < `CEH_TRAP_DEDIC);  // [RL9]
        end else if (misalign) begin
          next_kind    = CEH_K_ADDR;
          next_vec     = extb_i + `CEH_OFS_ADDR;          // [RL4]
          next_save_pc = instr_pc_i;                      // [RL6]
        end else if (instr_valid_i && fpu_exc_i) begin
          next_kind    = CEH_K_FPU;
          next_vec     = extb_i + `CEH_OFS_FPU;           // [RL1]
          next_save_pc = instr_pc_i;
        end else begin
          next_take    = 1'b0;
        end
        if (next_take) begin
          // Old mode is kept for the return; one level deep only,
          // nested entries rely on the stack for outer levels
          next_bk_ie  = next_psw_ie;
          next_bk_pm  = next_psw_pm;
          next_psw_ie = 1'b0;                             // [RL12]
          next_psw_pm = 1'b0;                             // [RL13]
        end
      end
      default: begin
        next_state = CEH_ST_BOOT;
      end
    endcase
  end

  // ==========================================================
  // Registers; clock enable freezes everything
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state   <= CEH_ST_BOOT;
      take    <= 1'b0;
      kind    <= CEH_K_NONE;
      vec     <= 32'h0000_0000;
      save_pc <= 32'h0000_0000;
      irq_ack <= 1'b0;
      dedic   <= 1'b0;
      psw_ie  <= `CEH_PSW_IE_RST;
      psw_pm  <= `CEH_PSW_PM_RST;
      bk_ie   <= `CEH_PSW_IE_RST;
      bk_pm   <= `CEH_PSW_PM_RST;
      stat0   <= `CEH_STAT_RST;
      stat1   <= `CEH_STAT_RST;
      stat2   <= `CEH_STAT_RST;
    end else if (en_i) begin
      state   <= next_state;
      take    <= next_take;
      kind    <= next_kind;
      vec     <= next_vec;
      save_pc <= next_save_pc;
      irq_ack <= next_irq_ack;
      dedic   <= next_dedic;
      psw_ie  <= next_psw_ie;
      psw_pm  <= next_psw_pm;
      bk_ie   <= next_bk_ie;
      bk_pm   <= next_bk_pm;
      stat0   <= next_stat0;
      stat1   <= next_stat1;
      stat2   <= next_stat2;
    end
  end

  // ==========================================================
  // Outputs straight from flops
  assign take_o       = take;
  assign kind_o       = kind;
  assign vec_o        = vec;
  assign save_pc_o    = save_pc;
  assign irq_ack_o    = irq_ack;
  assign dedic_trap_o = dedic;
  assign psw_ie_o     = psw_ie;
  assign psw_pm_o     = psw_pm;
  assign rst_stat0_o  = stat0;
  assign rst_stat1_o  = stat1;
  assign rst_stat2_o  = stat2;

endmodule

// file: test/ceh_exception_unit_properties.sv
`timescale 1ns/100ps
`include "ceh_params.svh"
module ceh_exception_unit_properties (
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire logic               en_i,
  input wire logic               instr_valid_i,
  input wire logic               undef_op_i,
  input wire logic               nmi_i,
  input wire logic               irq_i,
  input wire logic [3:0]         irq_level_i,
  input wire logic [7:0]         irq_vec_i,
  input wire logic [31:0]        intb_i,
  input wire logic [31:0]        extb_i,
  input wire logic [31:0]        fintv_i,
  input wire logic [31:0]        instr_pc_i,
  input wire logic [31:0]        opnd_addr_i,
  input wire logic               take_o,
  input wire ceh_pkg::ceh_kind_t kind_o,
  input wire logic [31:0]        vec_o,
  input wire logic [31:0]        save_pc_o,
  input wire logic               irq_ack_o,
  input wire logic               psw_ie_o,
  input wire logic               psw_pm_o
);
  import ceh_pkg::*;
  // ==========================================================
  // Exception entry relations
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Reset entry leaves the enable set; every other entry must clear it
  chk_ie_cleared: assert property (take_o && kind_o != CEH_K_RESET |-> !psw_ie_o)
    else $error("interrupt enable left set on entry");
  chk_irq_gated: assert property (irq_ack_o |-> $past(psw_ie_o))
    else $error("interrupt accepted while disabled");
  chk_super_mode: assert property (take_o |-> !psw_pm_o)
    else $error("entry not in supervisor mode");
  chk_reset_vec: assert property (kind_o == CEH_K_RESET |-> vec_o == `CEH_RESET_VEC)
    else $error("reset vector wrong");
  chk_nmi_table: assert property (kind_o == CEH_K_NMI |->
    vec_o == $past(extb_i) + `CEH_OFS_NMI)
    else $error("nmi vector wrong");
  chk_irq_table: assert property (kind_o == CEH_K_IRQ |->
    vec_o == $past(intb_i) + {22'h0, $past(irq_vec_i), 2'b00})
    else $error("interrupt vector wrong");
  chk_fast_path: assert property (kind_o == CEH_K_FAST |->
    vec_o == $past(fintv_i) && $past(irq_level_i) == 4'hF)
    else $error("fast interrupt wrong");
  chk_addr_pc: assert property (kind_o == CEH_K_ADDR |->
    save_pc_o == $past(instr_pc_i) && $past(opnd_addr_i[1:0]) != 2'h0)
    else $error("address exception wrong");
  chk_undef_take: assert property ($past(nrst_i) && en_i && instr_valid_i && undef_op_i
    && !nmi_i && !irq_i |=> take_o && kind_o == CEH_K_UNDEF)
    else $error("undefined opcode not taken");
endmodule
bind ceh_exception_unit ceh_exception_unit_properties u_chk (.clk_i, .nrst_i, .en_i,
  .instr_valid_i, .undef_op_i, .nmi_i, .irq_i, .irq_level_i, .irq_vec_i, .intb_i, .extb_i,
  .fintv_i, .instr_pc_i, .opnd_addr_i, .take_o, .kind_o, .vec_o, .save_pc_o, .irq_ack_o,
  .psw_ie_o, .psw_pm_o);

// file: test/ceh_exception_unit_tb.sv
`timescale 1ns/100ps
`include "ceh_params.svh"
module ceh_exception_unit_tb;
  import ceh_pkg::*;
  logic        clk_i, nrst_i, en_i, instr_valid_i, undef_op_i, priv_op_i, fpu_exc_i, trap_i;
  logic        break_trap_instruction_i, opnd64_i, rte_i, psw_wr_i, psw_wr_ie_i, psw_wr_pm_i;
  logic        nmi_i, irq_i, irq_fast_i, go, take_o, irq_ack_o, dedic_trap_o, psw_ie_o, psw_pm_o;
  logic [3:0]  ipl_i, irq_level_i;
  logic [7:0]  c0, c1, c2, trap_num_i, irq_vec_i, s0, s1, s2;
  logic [31:0] intb_i, extb_i, fintv_i, instr_pc_i, resume_pc_i, opnd_addr_i, vec_o, save_pc_o;
  ceh_kind_t   kind_o;
  int          n_errors, compares;
  ceh_exception_unit uut (.clk_i, .nrst_i, .en_i, .rst_cause0_i(c0), .rst_cause1_i(c1),
    .rst_cause2_i(c2), .intb_i, .extb_i, .fintv_i, .ipl_i, .instr_valid_i, .instr_pc_i,
    .resume_pc_i, .undef_op_i, .priv_op_i, .fpu_exc_i, .trap_i, .break_trap_instruction_i,
    .trap_num_i, .opnd64_i, .opnd_addr_i, .rte_i, .psw_wr_i, .psw_wr_ie_i, .psw_wr_pm_i,
    .nmi_i, .irq_i, .irq_level_i, .irq_vec_i, .irq_fast_i, .take_o, .kind_o, .vec_o,
    .save_pc_o, .irq_ack_o, .dedic_trap_o, .psw_ie_o, .psw_pm_o, .rst_stat0_o(s0),
    .rst_stat1_o(s1), .rst_stat2_o(s2));
  ceh_irq_model mdl (.clk_i, .go_i(go), .ack_i(irq_ack_o), .irq_o(irq_i));
  // ==========================================================
  // Clock, watchdog and shared helpers
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
  task print_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Pulses and instruction causes drop after every edge; irq fields stay put
  task step;
    @(posedge clk_i);
    #1;
    {instr_valid_i, undef_op_i, priv_op_i, fpu_exc_i, trap_i, go, nmi_i} = '0;
    {break_trap_instruction_i, opnd64_i, rte_i, psw_wr_i, psw_wr_ie_i, psw_wr_pm_i} = '0;
  endtask
  // Entry checks, then a return so the next scenario starts enabled
  task take(input ceh_kind_t k, input logic [31:0] v, input logic [31:0] p);
    chk(take_o, 1'b1);
    chk(kind_o, k);
    chk(vec_o, v);
    chk(save_pc_o, p);
    chk(psw_ie_o, 1'b0);
    chk(psw_pm_o, 1'b0);
    rte_i = 1'b1;
    step();
  endtask
  // ==========================================================
  // Scenarios
  task t_reset(input logic [7:0] a);
    nrst_i = 1'b0;
    {c0, c1, c2} = {a, ~a, a ^ 8'h5A};
    repeat (4) step();
    chk(psw_ie_o, 1'b1);
    nrst_i = 1'b1;
    step();
    chk(kind_o, CEH_K_RESET);
    chk(vec_o, `CEH_RESET_VEC);
    chk({s0, s1, s2}, {8'h00, a, ~a, a ^ 8'h5A});
  endtask
  task t_irq;
    {irq_level_i, ipl_i, irq_vec_i, go} = {4'h5, 4'h2, 8'h21, 1'b1};
    repeat (2) step();
    chk(irq_ack_o, 1'b1);
    chk(take_o, 1'b1);
    step();
    chk(take_o, 1'b0);
    rte_i = 1'b1;
    step();
    chk(psw_ie_o, 1'b1);
    {irq_level_i, irq_fast_i, go} = {4'hF, 1'b1, 1'b1};
    repeat (2) step();
    take(CEH_K_FAST, fintv_i, resume_pc_i);
    irq_fast_i = 1'b0;
  endtask
  task t_nmi;
    en_i = 1'b0;
    nmi_i = 1'b1;
    step();
    chk(take_o, 1'b0);
    en_i = 1'b1;
    nmi_i = 1'b1;
    step();
    take(CEH_K_NMI, extb_i + `CEH_OFS_NMI, resume_pc_i);
  endtask
  task t_instr;
    {instr_valid_i, undef_op_i} = 2'b11;
    step();
    take(CEH_K_UNDEF, extb_i + `CEH_OFS_UNDEF, instr_pc_i);
    {instr_valid_i, trap_i, trap_num_i} = {2'b11, 8'h0F};
    step();
    chk(dedic_trap_o, 1'b1);
    take(CEH_K_TRAP, intb_i + 32'h0000_003C, resume_pc_i);
    {instr_valid_i, trap_i, trap_num_i} = {2'b11, 8'h10};
    step();
    chk(dedic_trap_o, 1'b0);
    take(CEH_K_TRAP, intb_i + 32'h0000_0040, resume_pc_i);
    {instr_valid_i, break_trap_instruction_i} = 2'b11;
    step();
    take(CEH_K_TRAP, intb_i, resume_pc_i);
    {instr_valid_i, opnd64_i, opnd_addr_i} = {2'b11, 32'h0000_2002};
    step();
    take(CEH_K_ADDR, extb_i + `CEH_OFS_ADDR, instr_pc_i);
    {instr_valid_i, opnd64_i, opnd_addr_i} = {2'b11, 32'h0000_2004};
    step();
    chk(take_o, 1'b0);
    {instr_valid_i, fpu_exc_i} = 2'b11;
    step();
    take(CEH_K_FPU, extb_i + `CEH_OFS_FPU, instr_pc_i);
  endtask
  task t_mode;
    {instr_valid_i, priv_op_i} = 2'b11;
    step();
    chk(take_o, 1'b0);
    {psw_wr_i, psw_wr_ie_i, psw_wr_pm_i} = 3'b111;
    step();
    {instr_valid_i, priv_op_i} = 2'b11;
    step();
    take(CEH_K_PRIV, extb_i + `CEH_OFS_PRIV, instr_pc_i);
    chk(psw_pm_o, 1'b1);
  endtask
  initial begin
    // Reset and the model's request go low at once, so no unknown reaches the model
    {nrst_i, go, irq_fast_i, ipl_i, irq_level_i, irq_vec_i, trap_num_i, opnd_addr_i} = '0;
    en_i = 1'b1;
    {intb_i, extb_i, fintv_i} = {32'h0001_0000, 32'h0002_0000, 32'h0003_0000};
    {instr_pc_i, resume_pc_i} = {32'h0000_1000, 32'h0000_1004};
    {n_errors, compares} = '0;
    t_reset(8'h01);
    t_irq();
    t_nmi();
    t_instr();
    t_mode();
    t_reset(8'h80);
    print_verdict();
  end
endmodule

// file: test/ceh_irq_model.sv
`timescale 1ns/100ps
module ceh_irq_model (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic ack_i,
  output logic      irq_o
);
  // ==========================================================
  // Request held until acknowledged; it is never withdrawn early
  initial irq_o = 1'b0;
  always @(posedge clk_i) begin
    irq_o <= #1 ack_i ? 1'b0 : (go_i ? 1'b1 : irq_o);
  end
endmodule
